// *** core/adc_output_format_control.sv ***
// Pipeline, power-down and output stage of the sampling converter
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Format select high gives twos complement
// - Twos complement inverts only the MSB
// - Positive full scale and zero codes fixed
// - Negative full scale codes fixed
// - Over-range saturates to selected full scale
// - Active-low enable drives, else high impedance
// - Power-down stops conversion, keeps reference
// - Power-down discards pipeline, refills after latency
// - Each clock with CLK_EN high and no power-down request advances samples one stage
module adc_output_format_control
  import conv_fmt_pkg::*;
#(
  parameter int LATENCY = LATENCY_DEF
)
(
  // Clock and control
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic CLK_EN,
  // Pins from the outside world
  input wire logic TWOS_COMPLEMENT_SELECT,
  input wire logic POWER_DOWN_REQUEST,
  input wire logic OUTPUT_ENABLE_N,
  // Raw quantiser result
  input wire logic [SAMPLE_W-1:0] RAW_CODE,
  input wire logic RAW_OVER,
  input wire logic RAW_UNDER,
  // Data and power status outputs
  output logic [SAMPLE_W-1:0] DATA_OUT,
  output logic [SAMPLE_W-1:0] DATA_OE,
  output logic DATA_VALID,
  output logic REFERENCE_ACTIVE,
  output logic CONVERTER_ACTIVE
);
  localparam int CNT_W = $clog2(LATENCY + 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LATENCY - 1);
  // Pins read as twos complement select, powered down and disabled during reset
  localparam logic [2:0] SYNC_IDLE = 3'h7;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic twos_sel;
  logic pd_req;
  logic oe_n;

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      meta_ff <= SYNC_IDLE;
      sync_ff <= SYNC_IDLE;
    end
    else if (CLK_EN)
    begin
      meta_ff <= {TWOS_COMPLEMENT_SELECT, POWER_DOWN_REQUEST, OUTPUT_ENABLE_N};
      sync_ff <= meta_ff;
    end
  end

  assign twos_sel = sync_ff[2];
  assign pd_req = sync_ff[1];
  assign oe_n = sync_ff[0];

  ////////////////////////////////////////////////////////////////////////
  // Power state
  pwr_state_t state_ff;
  pwr_state_t nxt_state;
  logic [CNT_W-1:0] fill_ff;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_OFF:
        if (!pd_req)
          nxt_state = ST_FILL;
      ST_FILL:
        if (pd_req)
          nxt_state = ST_OFF;
        else if (fill_ff == CNT_LAST)
          nxt_state = ST_RUN;
      ST_RUN:
        if (pd_req)
          nxt_state = ST_OFF;
      default:
        nxt_state = ST_OFF;
    endcase
  end

  // Reset enters power-down so the pipeline starts empty
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      state_ff <= ST_OFF;
    else if (CLK_EN)
      state_ff <= nxt_state;
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      fill_ff <= CNT_ZERO;
    else if (CLK_EN)
    begin
      if (state_ff != ST_FILL)
        fill_ff <= CNT_ZERO;
      else
        fill_ff <= fill_ff + CNT_W'(1);
    end
  end

  assign CONVERTER_ACTIVE = (state_ff != ST_OFF);
  // Reference never sleeps, so wake-up is quick
  assign REFERENCE_ACTIVE = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Conversion pipeline
  stage_t pipe_ff [LATENCY];
  stage_t head;

  always_comb
  begin
    head.code = RAW_CODE;
    head.over = RAW_OVER;
    head.under = RAW_UNDER & ~RAW_OVER;
    head.valid = (state_ff != ST_OFF);
  end

  genvar g;
  generate
    for (g = 0; g < LATENCY; g++)
    begin : g_stage
      // Chosen at elaboration so stage 0 never indexes below the array
      stage_t feed;
      if (g == 0)
      begin : g_head
        assign feed = head;
      end
      else
      begin : g_link
        assign feed = pipe_ff[g-1];
      end
      always_ff @(posedge CLOCK)
      begin
        if (SRST)
          pipe_ff[g] <= '0;
        else if (CLK_EN)
        begin
          if (pd_req)
            pipe_ff[g] <= '0;
          else
            pipe_ff[g] <= feed;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Output register and tri-state control
  logic [SAMPLE_W-1:0] fmt_word;

  code_formatter u_fmt (
    .in_stage(pipe_ff[LATENCY-1]),
    .twos_sel(twos_sel),
    .word(fmt_word)
  );

  // Words from an empty last stage read as bipolar zero, never stale data
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      DATA_OUT <= OB_ZERO;
      DATA_VALID <= 1'b0;
    end
    else if (CLK_EN)
    begin
      DATA_VALID <= pipe_ff[LATENCY-1].valid && !pd_req;
      DATA_OUT <= pipe_ff[LATENCY-1].valid ? fmt_word : (twos_sel ? '0 : OB_ZERO);
    end
  end

  // Disable is bitwise so the pad ring can tri-state each line
  assign DATA_OE = {SAMPLE_W{~oe_n}};

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  // Clamp worked out apart from the formatter, so checks do not echo it
  logic [SAMPLE_W-1:0] chk_ob;

  always_comb
  begin
    chk_ob = pipe_ff[LATENCY-1].code;
    if (pipe_ff[LATENCY-1].under)
      chk_ob = OB_NEG_FULL;
    if (pipe_ff[LATENCY-1].over)
      chk_ob = OB_POS_FULL;
  end

  a_pd_flush: assert property (pd_req && CLK_EN |=> !pipe_ff[0].valid)
    else $error("pipeline not flushed under power-down");
  a_oe_follow: assert property (oe_n |-> DATA_OE == '0)
    else $error("outputs driven while disabled");
  a_oe_drive: assert property (!oe_n |-> DATA_OE == '1)
    else $error("outputs not driven while enabled");
  a_stage_shift: assert property (CLK_EN && !pd_req |=> pipe_ff[1] == $past(pipe_ff[0]))
    else $error("pipeline did not advance");
  a_fmt_msb: assert property (CLK_EN && pipe_ff[LATENCY-1].valid
    |=> (DATA_OUT[MSB_POS-1:0] == $past(chk_ob[MSB_POS-1:0])))
    else $error("low bits differ between codings");
  a_sat_pos: assert property (CLK_EN && pipe_ff[LATENCY-1].valid
    && pipe_ff[LATENCY-1].over
    |=> DATA_OUT == ($past(twos_sel) ? (OB_POS_FULL ^ MSB_MASK) : OB_POS_FULL))
    else $error("positive over-range not saturated");
  a_sat_neg: assert property (CLK_EN && pipe_ff[LATENCY-1].valid
    && pipe_ff[LATENCY-1].under
    |=> DATA_OUT == ($past(twos_sel) ? (OB_NEG_FULL ^ MSB_MASK) : OB_NEG_FULL))
    else $error("negative over-range not saturated");
  a_fmt_sel: assert property (CLK_EN && pipe_ff[LATENCY-1].valid
    |=> DATA_OUT[MSB_POS] == ($past(twos_sel) ^ $past(chk_ob[MSB_POS])))
    else $error("format select not applied");
  a_wake_gap: assert property (state_ff == ST_OFF && CLK_EN ##1 state_ff == ST_FILL
    |-> !DATA_VALID)
    else $error("valid before pipeline refilled");
  a_active: assert property (pd_req && CLK_EN |=> !CONVERTER_ACTIVE)
    else $error("converter awake under power-down");

  c_wake: cover property (state_ff == ST_FILL ##1 state_ff == ST_RUN);
  c_twos: cover property (DATA_VALID && twos_sel);
  c_sat: cover property (pipe_ff[LATENCY-1].valid && pipe_ff[LATENCY-1].over);
  c_tri: cover property (oe_n ##1 !oe_n);
endmodule : adc_output_format_control
`default_nettype wire

// *** core/code_formatter.sv ***
// Clamp and output-code formatter for one sample
`timescale 1ns/1ps
`default_nettype none
module code_formatter
  import conv_fmt_pkg::*;
(
  // Sample in
  input wire stage_t in_stage,
  input wire logic twos_sel,
  // Formatted word
  output logic [SAMPLE_W-1:0] word
);
  logic [SAMPLE_W-1:0] offset_binary_code;

  always_comb
  begin
    if (in_stage.over)
      offset_binary_code = OB_POS_FULL;
    else if (in_stage.under)
      offset_binary_code = OB_NEG_FULL;
    else
      offset_binary_code = in_stage.code;
    // Only the top bit differs between the two codings
    word = twos_sel ? (offset_binary_code ^ MSB_MASK) : offset_binary_code;
  end
endmodule : code_formatter
`default_nettype wire

// *** core/conv_fmt_pkg.sv ***
// Shared constants and carrier types for the converter output stage
package conv_fmt_pkg;
  localparam int SAMPLE_W = 14;
  localparam int LATENCY_DEF = 6;
  localparam int MSB_POS = SAMPLE_W - 1;
  localparam logic [13:0] OB_POS_FULL = 14'h3FFF;
  localparam logic [13:0] OB_NEG_FULL = 14'h0000;
  localparam logic [13:0] OB_ZERO = 14'h2000;
  localparam logic [13:0] MSB_MASK = 14'h2000;
  localparam real MIN_RATE_MHZ = 1.0;
  localparam real CLOCK_MHZ = 250.0;

  // One pipeline entry: raw code plus range flags
  typedef struct packed {
    logic [SAMPLE_W-1:0] code;
    logic over;
    logic under;
    logic valid;
  } stage_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_FILL = 3'b010,
    ST_RUN = 3'b100
  } pwr_state_t;
endpackage : conv_fmt_pkg

// *** verification/out_latch.sv ***
// Receiving latch model on the converter data pins
`timescale 1ns/1ps
`default_nettype none
module out_latch
  import conv_fmt_pkg::*;
(
  // Pins
  input wire logic clk,
  input wire logic [SAMPLE_W-1:0] data,
  input wire logic [SAMPLE_W-1:0] oe,
  // Level seen by the latch
  output logic [SAMPLE_W-1:0] pin
);
  logic [SAMPLE_W-1:0] last_ff = '0;
  // Released bits flip each cycle so a stale word never matches
  assign pin = (data & oe) | (~last_ff & ~oe);
  always_ff @(posedge clk)
    last_ff <= pin;
endmodule : out_latch
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the converter output stage
`timescale 1ns/1ps
`default_nettype none
module tb;
  import conv_fmt_pkg::*;
  localparam int L = 2;
  logic clk = 0, srst = 1, twos = 0, pd = 1, oe_n = 0, ov = 0, un = 0, vld, ref_on, conv_on;
  logic [13:0] raw = 14'h0000, dout, doe, pin, tail = 14'h0000, ex;
  logic [13:0] q[$];
  logic [31:0] r;
  int bad_count = 0, check_count = 0, rel = 0, seed = 32'h19e0_a646;
  bit first = 0;
  // Sample clock far above the minimum rate
  always #2 clk = ~clk;
  adc_output_format_control #(.LATENCY(L)) adc_output_format_control_inst (.CLOCK(clk),
    .SRST(srst), .CLK_EN(1'b1), .TWOS_COMPLEMENT_SELECT(twos), .POWER_DOWN_REQUEST(pd),
    .OUTPUT_ENABLE_N(oe_n), .RAW_CODE(raw), .RAW_OVER(ov), .RAW_UNDER(un), .DATA_OUT(dout),
    .DATA_OE(doe), .DATA_VALID(vld), .REFERENCE_ACTIVE(ref_on), .CONVERTER_ACTIVE(conv_on));
  out_latch out_latch_inst (.clk(clk), .data(dout), .oe(doe), .pin(pin));
  ////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [13:0] fmt(logic [13:0] c, logic o, logic u, logic t);
    logic [13:0] w;
    w = o ? OB_POS_FULL : (u ? OB_NEG_FULL : c);
    return t ? w ^ MSB_MASK : w;
  endfunction : fmt
  task automatic check(string nm, logic [13:0] seen, logic [13:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////////////
  // Oldest note pairs with each valid word; held input covers the tail
  always @(posedge clk)
  begin
    #1;
    rel++;
    if (first && rel > 40)
    begin
      bad_count++;
      wrap_up();
    end
    else if (vld === 1'b1)
    begin
      // Two sync flops, state wake-up, L stages, then the output register
      if (first)
        check("refill", 14'(rel), 14'(L + 4));
      first = 0;
      ex = (q.size() > 0) ? q.pop_front() : tail;
      check("word", dout, ex);
      if (!oe_n)
        check("pin", pin, ex);
    end
  end
  initial
  begin
    repeat (20) @(negedge clk);
    srst = 0;
    for (int p = 0; p < 3; p++)
    begin
      // Format and enable move only inside power-down
      pd = 1;
      repeat (4) @(negedge clk);
      twos = p[0];
      oe_n = (p == 2);
      repeat (L + 8) @(negedge clk);
      q.delete();
      check("valid", 14'(vld), 14'h0000);
      check("conv", 14'(conv_on), 14'h0000);
      check("ref", 14'(ref_on), 14'h0001);
      check("oe", doe, {14{~oe_n}});
      // Steady low while streaming
      pd = 0;
      rel = 0;
      first = 1;
      for (int i = 0; i < 40; i++)
      begin
        if (i > 0)
          @(negedge clk);
        r = $random(seed);
        raw = (i == 3) ? OB_POS_FULL : (i == 4) ? OB_ZERO : (i == 5) ? OB_NEG_FULL : r[13:0];
        ov = (i == 6) || (i == 8) || (i > 8 && r[19:16] == 0);
        un = (i == 7) || (i == 8) || (i > 8 && r[23:20] == 0);
        tail = fmt(raw, ov, un, twos);
        // First three samples after release are lost to sync and wake-up
        if (i >= 3)
          q.push_back(tail);
      end
      check("conv run", 14'(conv_on), 14'h0001);
    end
    pd = 1;
    repeat (L + 8) @(negedge clk);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
